//--- logic/usb_rx_endpoint_control.v
// Receive endpoint FIFOs, their command and status registers, and the APB slave.
`timescale 1ns/1ps
`include "usb_rx_map.vh"

module usb_rx_endpoint_control (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output wire        pslverr,
  // Token and packet stream from the MAC
  input  wire        tok_valid,
  input  wire [1:0]  tok_kind,
  input  wire [1:0]  tok_ep,
  input  wire        pkt_byte_valid,
  input  wire [7:0]  pkt_byte,
  input  wire        pkt_end,
  input  wire        pkt_bad,
  input  wire [3:0]  ep_stall,
  // Handshake requests and status
  output reg         hs_ack,
  output reg         hs_nak,
  output reg         hs_stall,
  output wire        rx_busy,
  output wire        irq
);

  // ****************************************
  // State
  // ****************************************
  reg  [7:0] mem [0:255];
  reg  [6:0] wr_ptr [0:3];
  reg  [6:0] rd_ptr [0:3];
  reg  [3:0] rx_en;
  reg  [3:0] ignore_setup_tokens;
  reg  [3:0] flush_pend;
  reg  [3:0] setup_lock;
  reg  [3:0] sts_err;
  reg  [3:0] sts_setup;
  reg  [3:0] sts_tog;
  reg  [3:0] sts_last;
  reg  [7:0] wlim;
  reg  [7:0] events;
  reg  [7:0] mask;
  reg  [2:0] state;
  reg  [1:0] cur_ep;
  reg        cur_setup;
  reg  [1:0] nbytes;
  reg  [7:0] hold0;
  reg  [7:0] hold1;
  reg        tog_cap;
  reg        ovf;
  reg        wrote;
  reg        hit;
  reg  [2:0] kind;
  reg  [1:0] sel_ep;
  reg  [7:0] rd_val;
  reg  [6:0] thr;
  integer    i;

  wire       acc     = psel & penable;
  wire       done    = acc & pready;
  wire [5:0] idx     = paddr[7:2];
  wire       aligned = (paddr[1:0] == 2'h0);
  wire       ok      = hit & aligned;
  wire [6:0] occ_sel = wr_ptr[sel_ep] - rd_ptr[sel_ep];
  wire [6:0] occ_cur = wr_ptr[cur_ep] - rd_ptr[cur_ep];
  wire [6:0] cap_cur = cap_of(cur_ep);
  wire       full    = (occ_cur == cap_cur);
  wire [6:0] occ_nxt = occ_cur + 7'h01;
  wire       take    = pkt_byte_valid & (state == `ST_ACCEPT);
  wire       mem_we  = take & (nbytes == `NB_FULL) & ~full;
  wire [7:0] waddr   = {cur_ep, wr_ptr[cur_ep][5:0] & mask_of(cur_ep)};
  wire [7:0] raddr   = {sel_ep, rd_ptr[sel_ep][5:0] & mask_of(sel_ep)};
  wire       rd_data = done & ~pwrite & ok & (kind == `KIND_DATA);
  wire       rd_sts  = done & ~pwrite & ok & (kind == `KIND_STATUS);
  wire       wr_cmd  = done & pwrite & ok & (kind == `KIND_COMMAND);
  wire       flush_now = wr_cmd & pwdata[`CMD_FLUSH];

  assign pslverr = pready & ~ok;
  assign rx_busy = (state != `ST_IDLE);
  assign irq     = |(events & mask);

  // Control endpoint has 8 bytes, pairs 1 and 2 have 32, pair 3 has 64.
  function [6:0] cap_of;
    input [1:0] ep;
    begin
      if (ep == `EP_CONTROL)
        cap_of = `CAP_EP0;
      else if (ep == `EP_PAIR3)
        cap_of = `CAP_PAIR3;
      else
        cap_of = `CAP_PAIR;
    end
  endfunction

  function [5:0] mask_of;
    input [1:0] ep;
    reg   [6:0] c;
    begin
      c = cap_of(ep) - 7'h01;
      mask_of = c[5:0];
    end
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  always @* begin
    hit = 1'b1;
    kind = `KIND_DATA;
    sel_ep = 2'h0;
    case (idx)
      `IDX_EP0_DATA: begin kind = `KIND_DATA; sel_ep = 2'h0; end
      `IDX_EP0_STATUS: begin kind = `KIND_STATUS; sel_ep = 2'h0; end
      `IDX_EP0_COMMAND: begin kind = `KIND_COMMAND; sel_ep = 2'h0; end
      `IDX_PAIR1_DATA: begin kind = `KIND_DATA; sel_ep = 2'h1; end
      `IDX_PAIR2_DATA: begin kind = `KIND_DATA; sel_ep = 2'h2; end
      `IDX_PAIR3_DATA: begin kind = `KIND_DATA; sel_ep = 2'h3; end
      `IDX_PAIR1_STATUS: begin kind = `KIND_STATUS; sel_ep = 2'h1; end
      `IDX_PAIR2_STATUS: begin kind = `KIND_STATUS; sel_ep = 2'h2; end
      `IDX_PAIR3_STATUS: begin kind = `KIND_STATUS; sel_ep = 2'h3; end
      `IDX_PAIR1_CMD: begin kind = `KIND_COMMAND; sel_ep = 2'h1; end
      `IDX_PAIR2_CMD: begin kind = `KIND_COMMAND; sel_ep = 2'h2; end
      `IDX_PAIR3_CMD: begin kind = `KIND_COMMAND; sel_ep = 2'h3; end
      `IDX_WARN_EVENTS: kind = `KIND_EVENTS;
      `IDX_WARN_MASK: kind = `KIND_MASK;
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Read value
  // ****************************************
  always @* begin
    rd_val = `RST_BYTE;
    case (kind)
      `KIND_DATA: begin
        if (occ_sel != `RST_PTR)
          rd_val = mem[raddr];
      end
      `KIND_STATUS: begin
        rd_val[`STS_ERR] = sts_err[sel_ep];
        rd_val[`STS_SETUP] = sts_setup[sel_ep];
        rd_val[`STS_TOGGLE] = sts_tog[sel_ep];
        rd_val[`STS_LAST] = sts_last[sel_ep];
        rd_val[3:0] = (|occ_sel[6:4]) ? `CNT_SATURATED : occ_sel[3:0];
      end
      `KIND_COMMAND: begin
        rd_val[`CMD_WLIM_HI:`CMD_WLIM_LO] = wlim[2*sel_ep +: 2];
        rd_val[`CMD_IGNORE_SETUP_TOKENS] = ignore_setup_tokens[sel_ep];
        rd_val[`CMD_RX_EN] = rx_en[sel_ep];
      end
      `KIND_EVENTS: rd_val = events;
      `KIND_MASK: rd_val = mask;
      default: rd_val = `RST_BYTE;
    endcase
  end

  // ****************************************
  // Warning threshold of the current endpoint
  // ****************************************
  always @* begin
    case (wlim[2*cur_ep +: 2])
      `WARN_OFF: thr = `RST_PTR;
      `WARN_LIM4: thr = `WARN_T4;
      `WARN_LIM8: thr = `WARN_T8;
      default: thr = `WARN_T16;
    endcase
  end

  // FIFO storage has no reset; pointers alone define its contents.
  always @(posedge ref_clk) begin
    if (mem_we)
      mem[waddr] <= hold1;
  end

  // ****************************************
  // APB handshake and read data
  // ****************************************
  // Every access takes one wait cycle so that read data leaves a flip-flop.
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready)
        prdata <= {24'h000000, (ok & ~pwrite) ? rd_val : `RST_BYTE};
    end
  end

  // ****************************************
  // Endpoint control and receive sequence
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 4; i = i + 1) begin
        wr_ptr[i] <= `RST_PTR;
        rd_ptr[i] <= `RST_PTR;
      end
      rx_en <= 4'h0;
      ignore_setup_tokens <= 4'h0;
      flush_pend <= 4'h0;
      setup_lock <= 4'h0;
      sts_err <= 4'h0;
      sts_setup <= 4'h0;
      sts_tog <= 4'h0;
      sts_last <= 4'h0;
      wlim <= 8'h00;
      events <= 8'h00;
      mask <= 8'h00;
      state <= `ST_IDLE;
      cur_ep <= 2'h0;
      cur_setup <= 1'b0;
      nbytes <= `NB_NONE;
      hold0 <= `RST_BYTE;
      hold1 <= `RST_BYTE;
      tog_cap <= 1'b0;
      ovf <= 1'b0;
      wrote <= 1'b0;
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      hs_stall <= 1'b0;
    end else begin
      hs_ack <= 1'b0;
      hs_nak <= 1'b0;
      hs_stall <= 1'b0;

      // Firmware side. Clears come first so that any hardware set below wins.
      if (rd_data && occ_sel != `RST_PTR)
        rd_ptr[sel_ep] <= rd_ptr[sel_ep] + 7'h01;
      if (rd_sts) begin
        sts_err[sel_ep] <= sts_err[sel_ep] & ~prdata[`STS_ERR];
        sts_setup[sel_ep] <= sts_setup[sel_ep] & ~prdata[`STS_SETUP];
        sts_tog[sel_ep] <= sts_tog[sel_ep] & ~prdata[`STS_TOGGLE];
        sts_last[sel_ep] <= sts_last[sel_ep] & ~prdata[`STS_LAST];
      end
      if (wr_cmd) begin
        rx_en[sel_ep] <= pwdata[`CMD_RX_EN];
        ignore_setup_tokens[sel_ep] <= pwdata[`CMD_IGNORE_SETUP_TOKENS];
        wlim[2*sel_ep +: 2] <= pwdata[`CMD_WLIM_HI:`CMD_WLIM_LO];
      end
      if (flush_now) begin
        // A flush that meets the end of the packet is done at once, or it would wait for the next packet to that endpoint.
        if (rx_busy && cur_ep == sel_ep && !pkt_end) begin
          flush_pend[sel_ep] <= 1'b1;
        end else begin
          wr_ptr[sel_ep] <= `RST_PTR;
          rd_ptr[sel_ep] <= `RST_PTR;
          setup_lock[sel_ep] <= 1'b0;
        end
      end
      if (done && pwrite && ok && kind == `KIND_EVENTS)
        events <= events & ~pwdata[7:0];
      if (done && pwrite && ok && kind == `KIND_MASK)
        mask <= pwdata[7:0];

      // Token decision.
      if (tok_valid && state == `ST_IDLE) begin
        cur_ep <= tok_ep;
        cur_setup <= (tok_kind == `TOK_SETUP);
        nbytes <= `NB_NONE;
        ovf <= 1'b0;
        wrote <= 1'b0;
        if (tok_kind != `TOK_SETUP)
          setup_lock[tok_ep] <= 1'b0;
        case (tok_kind)
          `TOK_OUT: begin
            if (ep_stall[tok_ep])
              state <= `ST_STALL;
            else if (rx_en[tok_ep] && !flush_pend[tok_ep])
              state <= `ST_ACCEPT;
            else
              state <= `ST_NAK;
          end
          `TOK_SETUP: begin
            if (ignore_setup_tokens[tok_ep])
              state <= `ST_IDLE;
            else if (setup_lock[tok_ep])
              state <= `ST_DROP_ACK;
            else if (flush_pend[tok_ep])
              state <= `ST_SILENT;
            else
              state <= `ST_ACCEPT;
          end
          default: state <= `ST_IDLE;
        endcase
      end

      // The PID is taken apart and the last two bytes are always held back,
      // so the CRC16 never reaches the FIFO.
      if (take) begin
        if (nbytes != `NB_FULL)
          nbytes <= nbytes + 2'h1;
        if (nbytes == `NB_NONE) begin
          tog_cap <= pkt_byte[`PID_DATA1_BIT];
        end else begin
          hold0 <= pkt_byte;
          hold1 <= hold0;
        end
        if (nbytes == `NB_FULL) begin
          if (full) begin
            ovf <= 1'b1;
          end else begin
            wr_ptr[cur_ep] <= wr_ptr[cur_ep] + 7'h01;
            wrote <= 1'b1;
            if (thr != `RST_PTR && occ_nxt >= thr)
              events[cur_ep] <= 1'b1;
          end
        end
      end

      // End of the data packet: handshake and status.
      if (pkt_end && rx_busy) begin
        state <= `ST_IDLE;
        case (state)
          `ST_ACCEPT: begin
            if (pkt_bad || ovf || nbytes != `NB_FULL) begin
              sts_err[cur_ep] <= 1'b1;
            end else begin
              hs_ack <= 1'b1;
              rx_en[cur_ep] <= 1'b0;
              sts_last[cur_ep] <= 1'b1;
              events[`EVT_DONE_BASE + cur_ep] <= 1'b1;
              if (wrote)
                sts_tog[cur_ep] <= tog_cap;
              if (cur_setup) begin
                sts_setup[cur_ep] <= 1'b1;
                setup_lock[cur_ep] <= 1'b1;
              end
            end
          end
          `ST_DROP_ACK: hs_ack <= 1'b1;
          `ST_NAK: hs_nak <= 1'b1;
          `ST_STALL: begin
            hs_stall <= 1'b1;
            rx_en[cur_ep] <= 1'b0;
          end
          default: hs_ack <= 1'b0;
        endcase
        if (flush_pend[cur_ep]) begin
          flush_pend[cur_ep] <= 1'b0;
          wr_ptr[cur_ep] <= `RST_PTR;
          rd_ptr[cur_ep] <= `RST_PTR;
          setup_lock[cur_ep] <= 1'b0;
        end
      end
    end
  end

endmodule // usb_rx_endpoint_control

//--- logic/usb_rx_map.vh
// Register indices, field positions, reset values and codes of the receive endpoint block.
`ifndef USB_RX_MAP_VH
`define USB_RX_MAP_VH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define IDX_EP0_DATA     6'h25
`define IDX_EP0_STATUS   6'h26
`define IDX_EP0_COMMAND  6'h27
`define IDX_PAIR1_DATA   6'h2D
`define IDX_PAIR1_STATUS 6'h2E
`define IDX_PAIR1_CMD    6'h2F
`define IDX_PAIR2_DATA   6'h35
`define IDX_PAIR2_STATUS 6'h36
`define IDX_PAIR2_CMD    6'h37
`define IDX_PAIR3_DATA   6'h3D
`define IDX_PAIR3_STATUS 6'h3E
`define IDX_PAIR3_CMD    6'h3F
`define IDX_WARN_EVENTS  6'h10
`define IDX_WARN_MASK    6'h11

// ****************************************
// Register kinds after decode
// ****************************************
`define KIND_DATA    3'h0
`define KIND_STATUS  3'h1
`define KIND_COMMAND 3'h2
`define KIND_EVENTS  3'h3
`define KIND_MASK    3'h4

// ****************************************
// Field positions
// ****************************************
`define CMD_RX_EN      0
`define CMD_IGNORE_SETUP_TOKENS  2
`define CMD_FLUSH      3
`define CMD_WLIM_LO    5
`define CMD_WLIM_HI    6
`define STS_ERR        7
`define STS_SETUP      6
`define STS_TOGGLE     5
`define STS_LAST       4
`define EVT_DONE_BASE  4
`define PID_DATA1_BIT  3

// ****************************************
// Values and limits
// ****************************************
`define CNT_SATURATED  4'hF
`define WARN_OFF       2'h0
`define WARN_LIM4      2'h1
`define WARN_LIM8      2'h2
`define WARN_T4        7'h04
`define WARN_T8        7'h08
`define WARN_T16       7'h10
`define CAP_EP0        7'h08
`define CAP_PAIR       7'h20
`define CAP_PAIR3      7'h40
`define EP_PAIR3       2'h3
`define EP_CONTROL     2'h0
`define RST_BYTE       8'h00
`define RST_PTR        7'h00

// ****************************************
// Token kinds from the MAC
// ****************************************
`define TOK_OUT    2'h0
`define TOK_SETUP  2'h1
`define TOK_IN     2'h2
`define TOK_OTHER  2'h3

// ****************************************
// Receive states
// ****************************************
`define ST_IDLE      3'h0
`define ST_ACCEPT    3'h1
`define ST_DROP_ACK  3'h2
`define ST_SILENT    3'h3
`define ST_NAK       3'h4
`define ST_STALL     3'h5

// Bytes seen in a packet, saturating: PID, one held, two held.
`define NB_NONE  2'h0
`define NB_PID   2'h1
`define NB_FULL  2'h3

`endif

//--- verif/usb_rx_checker_assertions.sv
// Concurrent checks on the ports of the receive endpoint block.
`timescale 1ns/1ps
module usb_rx_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        arst_n,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Packet side
  input wire        tok_valid,
  input wire [1:0]  tok_kind,
  input wire        pkt_end,
  input wire        hs_ack,
  input wire        hs_nak,
  input wire        hs_stall,
  input wire        rx_busy
);
  // ****************************************
  // Helpers
  // ****************************************
  wire       acc = psel & penable & pready & (paddr[1:0] == 2'h0);
  wire [5:0] idx = paddr[7:2];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready ##1 !pready)
    else $error("access phase not one wait state");
  a_cmd_map: assert property (acc && idx inside {6'h2F, 6'h37, 6'h3F} |-> !pslverr)
    else $error("command register refused");
  a_data_map: assert property (acc && idx inside {6'h2D, 6'h35, 6'h3D} |-> !pslverr)
    else $error("data register refused");
  a_status_map: assert property (acc && idx inside {6'h2E, 6'h36, 6'h3E} |-> !pslverr)
    else $error("status register refused");
  a_ep0_map: assert property (acc && idx inside {6'h25, 6'h26, 6'h27} |-> !pslverr)
    else $error("control endpoint register refused");
  a_misaligned: assert property (psel && pready && !pwrite && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned read not refused");
  a_hs_cause: assert property (hs_ack || hs_nak || hs_stall |-> $past(pkt_end) && $onehot({hs_ack, hs_nak, hs_stall}))
    else $error("handshake without end of packet");
  a_busy_end: assert property (rx_busy && pkt_end |=> !rx_busy)
    else $error("reception did not finish at end of packet");
  a_out_taken: assert property (tok_valid && !rx_busy && tok_kind == 2'h0 |=> rx_busy)
    else $error("OUT token not taken");
endmodule // usb_rx_checker

//--- verif/usb_host_model.sv
// Behavioural host that sends tokens and data packets to the receive block.
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input  wire       ref_clk,
  // Handshakes from the block
  input  wire       hs_ack,
  input  wire       hs_nak,
  input  wire       hs_stall,
  // Token and packet stream
  output reg        tok_valid,
  output reg  [1:0] tok_kind,
  output reg  [1:0] tok_ep,
  output reg        pkt_byte_valid,
  output reg  [7:0] pkt_byte,
  output reg        pkt_end,
  output reg        pkt_bad
);
  initial begin
    tok_valid = 1'b0;
    tok_kind = 2'h0;
    tok_ep = 2'h0;
    pkt_byte_valid = 1'b0;
    pkt_byte = 8'h00;
    pkt_end = 1'b0;
    pkt_bad = 1'b0;
  end
  // Mode 0 sends the token alone, 1 a good packet, 2 one with a bad CRC.
  task pkt(input [1:0] kind, input [1:0] ep, input [7:0] pid, input integer n,
           input [7:0] base, input [1:0] mode, output [2:0] hs);
    integer i;
    begin
      hs = 3'h0;
      @(posedge ref_clk);
      tok_valid <= 1'b1;
      tok_kind <= kind;
      tok_ep <= ep;
      @(posedge ref_clk);
      tok_valid <= 1'b0;
      for (i = -1; i < n + 2 && mode != 2'h0; i = i + 1) begin
        @(posedge ref_clk);
        pkt_byte_valid <= 1'b1;
        pkt_byte <= i < 0 ? pid : i < n ? base + i[7:0] : 8'hC3 ^ i[7:0];
      end
      if (mode != 2'h0) begin
        @(posedge ref_clk);
        pkt_byte_valid <= 1'b0;
        // A released byte lane must not keep showing the last value.
        pkt_byte <= ~pkt_byte;
        pkt_end <= 1'b1;
        pkt_bad <= mode == 2'h2;
      end
      repeat (3) begin
        @(posedge ref_clk);
        pkt_end <= 1'b0;
        pkt_bad <= 1'b0;
        hs = hs | {hs_ack, hs_nak, hs_stall};
      end
    end
  endtask
endmodule // usb_host_model

//--- verif/usb_rx_endpoint_control_tb_top.sv
// Top testbench of the receive endpoint block.
`timescale 1ns/1ps
`include "usb_rx_map.vh"
module usb_rx_endpoint_control_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  reg         ref_clk, arst_n, psel, penable, pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd_val;
  reg  [3:0]  ep_stall;
  reg         rd_err;
  reg  [2:0]  hs;
  wire [31:0] prdata;
  wire        pready, pslverr, rx_busy, irq, hs_ack, hs_nak, hs_stall;
  wire        tok_valid, pkt_byte_valid, pkt_end, pkt_bad;
  wire [1:0]  tok_kind, tok_ep;
  wire [7:0]  pkt_byte;
  integer     num_errors = 0, samples_checked = 0, cycles = 0, code, thr, i;
  usb_rx_endpoint_control dut (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_kind(tok_kind),
    .tok_ep(tok_ep), .pkt_byte_valid(pkt_byte_valid), .pkt_byte(pkt_byte),
    .pkt_end(pkt_end), .pkt_bad(pkt_bad), .ep_stall(ep_stall), .hs_ack(hs_ack),
    .hs_nak(hs_nak), .hs_stall(hs_stall), .rx_busy(rx_busy), .irq(irq));
  usb_host_model host (.ref_clk(ref_clk), .hs_ack(hs_ack), .hs_nak(hs_nak),
    .hs_stall(hs_stall), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep(tok_ep),
    .pkt_byte_valid(pkt_byte_valid), .pkt_byte(pkt_byte), .pkt_end(pkt_end),
    .pkt_bad(pkt_bad));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // ****************************************
  // APB master
  // ****************************************
  task apb(input w, input [5:0] idx, input [1:0] lo, input [7:0] d);
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, lo};
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd_val = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [5:0] idx, input [7:0] d);
    apb(1'b1, idx, 2'h0, d);
  endtask
  task rdc(input string nm, input [5:0] idx, input [31:0] exp);
    begin
      apb(1'b0, idx, 2'h0, 8'h00);
      check(nm, rd_val, exp);
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_map;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        rdc("reset value", 6'h25 + 6'(8 * (i / 3) + i % 3), 32'h0);
        check("mapped", {31'h0, rd_err}, 32'h0);
      end
      apb(1'b0, 6'h00, 2'h0, 8'h00);
      check("unmapped", {31'h0, rd_err}, 32'h1);
      apb(1'b0, `IDX_PAIR1_CMD, 2'h1, 8'h00);
      check("misaligned", {31'h0, rd_err}, 32'h1);
      $display("t_map done");
    end
  endtask
  task t_out;
    begin
      wr(`IDX_PAIR1_CMD, 8'h01);
      host.pkt(`TOK_OUT, 2'h1, 8'h4B, 3, 8'hA0, 2'h1, hs);
      check("out ack", {29'h0, hs}, 32'h4);
      rdc("out status", `IDX_PAIR1_STATUS, 32'h33);
      for (i = 0; i < 3; i = i + 1) rdc("payload", `IDX_PAIR1_DATA, 32'hA0 + i);
      rdc("enable off", `IDX_PAIR1_CMD, 32'h0);
      host.pkt(`TOK_OUT, 2'h1, 8'h4B, 1, 8'h00, 2'h1, hs);
      check("out nak", {29'h0, hs}, 32'h2);
      rdc("events", `IDX_WARN_EVENTS, 32'h20);
      wr(`IDX_WARN_EVENTS, 8'h20);
      rdc("events clear", `IDX_WARN_EVENTS, 32'h0);
      $display("t_out done");
    end
  endtask
  task t_setup;
    begin
      host.pkt(`TOK_SETUP, 2'h2, 8'hC3, 2, 8'h10, 2'h1, hs);
      check("setup ack", {29'h0, hs}, 32'h4);
      host.pkt(`TOK_SETUP, 2'h2, 8'hC3, 2, 8'h50, 2'h1, hs);
      check("repeat ack", {29'h0, hs}, 32'h4);
      rdc("setup status", `IDX_PAIR2_STATUS, 32'h52);
      rdc("setup byte", `IDX_PAIR2_DATA, 32'h10);
      rdc("setup byte", `IDX_PAIR2_DATA, 32'h11);
      rdc("setup drained", `IDX_PAIR2_STATUS, 32'h0);
      wr(`IDX_PAIR2_CMD, 8'h04);
      host.pkt(`TOK_SETUP, 2'h2, 8'hC3, 0, 8'h00, 2'h0, hs);
      check("ignored hs", {29'h0, hs}, 32'h0);
      check("ignored busy", {31'h0, rx_busy}, 32'h0);
      wr(`IDX_PAIR2_CMD, 8'h00);
      host.pkt(`TOK_IN, 2'h2, 8'h00, 0, 8'h00, 2'h0, hs);
      host.pkt(`TOK_SETUP, 2'h2, 8'hC3, 1, 8'h60, 2'h1, hs);
      check("setup after in", {29'h0, hs}, 32'h4);
      rdc("setup after in", `IDX_PAIR2_DATA, 32'h60);
      $display("t_setup done");
    end
  endtask
  task t_stall;
    begin
      ep_stall <= 4'h8;
      wr(`IDX_PAIR3_CMD, 8'h01);
      host.pkt(`TOK_OUT, 2'h3, 8'h4B, 1, 8'h00, 2'h1, hs);
      check("stall hs", {29'h0, hs}, 32'h1);
      rdc("stall enable", `IDX_PAIR3_CMD, 32'h0);
      ep_stall <= 4'h0;
      host.pkt(`TOK_SETUP, 2'h3, 8'hC3, 2, 8'h00, 2'h2, hs);
      check("bad setup hs", {29'h0, hs}, 32'h0);
      apb(1'b0, `IDX_PAIR3_STATUS, 2'h0, 8'h00);
      check("bad setup err", {31'h0, rd_val[7]}, 32'h1);
      wr(`IDX_PAIR3_CMD, 8'h08);
      wr(`IDX_EP0_COMMAND, 8'h01);
      host.pkt(`TOK_OUT, 2'h0, 8'h4B, 9, 8'h00, 2'h1, hs);
      check("overflow hs", {29'h0, hs}, 32'h0);
      rdc("overflow status", `IDX_EP0_STATUS, 32'h88);
      wr(`IDX_EP0_COMMAND, 8'h08);
      $display("t_stall done");
    end
  endtask
  task t_warn;
    begin
      wr(`IDX_WARN_MASK, 8'h02);
      for (code = 0; code < 4; code = code + 1) begin
        thr = code == 0 ? 16 : 2 << code;
        wr(`IDX_PAIR1_CMD, 8'h08);
        wr(`IDX_WARN_EVENTS, 8'hFF);
        wr(`IDX_PAIR1_CMD, 8'(code * 32 + 1));
        host.pkt(`TOK_OUT, 2'h1, 8'h4B, thr - 1, 8'h00, 2'h1, hs);
        check("irq below", {31'h0, irq}, 32'h0);
        wr(`IDX_PAIR1_CMD, 8'(code * 32 + 1));
        host.pkt(`TOK_OUT, 2'h1, 8'hC3, 1, 8'h00, 2'h1, hs);
        rdc("warn flag", `IDX_WARN_EVENTS, code == 0 ? 32'h20 : 32'h22);
        check("irq", {31'h0, irq}, code == 0 ? 32'h0 : 32'h1);
        rdc("count", `IDX_PAIR1_STATUS, thr > 15 ? 32'h1F : 32'h10 + thr);
      end
      wr(`IDX_WARN_EVENTS, 8'hFF);
      repeat (2) @(posedge ref_clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("t_warn done");
    end
  endtask
  task t_flush;
    begin
      wr(`IDX_PAIR2_CMD, 8'h01);
      fork
        host.pkt(`TOK_OUT, 2'h2, 8'h4B, 6, 8'h30, 2'h1, hs);
        begin
          repeat (4) @(posedge ref_clk);
          wr(`IDX_PAIR2_CMD, 8'h08);
        end
      join
      check("flush ack", {29'h0, hs}, 32'h4);
      apb(1'b0, `IDX_PAIR2_STATUS, 2'h0, 8'h00);
      check("flushed count", {28'h0, rd_val[3:0]}, 32'h0);
      rdc("flushed data", `IDX_PAIR2_DATA, 32'h0);
      wr(`IDX_PAIR2_CMD, 8'h01);
      host.pkt(`TOK_OUT, 2'h2, 8'h4B, 1, 8'h77, 2'h1, hs);
      rdc("pointer reset", `IDX_PAIR2_DATA, 32'h77);
      $display("t_flush done");
    end
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ep_stall = 4'h0;
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_map;
    t_out;
    t_setup;
    t_stall;
    t_warn;
    t_flush;
    finish_test;
  end
endmodule // usb_rx_endpoint_control_tb_top
bind usb_rx_endpoint_control usb_rx_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tok_valid(tok_valid), .tok_kind(tok_kind),
  .pkt_end(pkt_end), .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_stall(hs_stall),
  .rx_busy(rx_busy));
